// ===== hdl/dpgw_pkg.sv
// Constants for the dual port general purpose I/O block with wake-up.
// Assumes a core data-memory bus with one-cycle read and write strobes.
package dpgw_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_PA_DATA = 4'h0;
    localparam logic [3:0] OFS_PA_DIR = 4'h1;
    localparam logic [3:0] OFS_PA_PU = 4'h2;
    localparam logic [3:0] OFS_PA_WU = 4'h3;
    localparam logic [3:0] OFS_PB_DATA = 4'h4;
    localparam logic [3:0] OFS_PB_DIR = 4'h5;
    localparam logic [3:0] OFS_PB_PU = 4'h6;
    localparam logic [3:0] OFS_DRIVE = 4'h7;
    localparam logic [3:0] OFS_FSEL_LO = 4'h8;
    localparam logic [3:0] OFS_FSEL_HI = 4'h9;
    localparam logic [3:0] OFS_IN_ROUTE = 4'hA;
    localparam logic [3:0] OFS_UNLOCK = 4'hB;

    // ------------------------------------------------------------------
    // Implemented bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_PB = 8'h03;
    localparam logic [7:0] MASK_DRIVE = 8'h3F;
    localparam logic [7:0] MASK_IN_ROUTE = 8'h03;
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] UNLOCK_KEY = 8'hCA;

    // ------------------------------------------------------------------
    // Field positions and field values
    // ------------------------------------------------------------------
    localparam int DRV_PA_LO_LSB = 0;
    localparam int DRV_PA_HI_LSB = 2;
    localparam int DRV_PB_LSB = 4;
    localparam logic [1:0] RX_SRC_PIN3 = 2'h1;
    localparam logic [1:0] FSEL_ALT2 = 2'h2;
    localparam logic [1:0] FSEL_ALT3 = 2'h3;

endpackage

// ===== hdl/dpgw_pad.sv
// Per-pin pad control for one port: drive, enable, pull-high and readback.
// Assumes function selects and peripheral drive come from the parent.
`timescale 1ns/1ps
module dpgw_pad #(
    parameter int WIDTH = 8
) (
    // Port configuration
    input wire logic [WIDTH-1:0] data,
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] pu,
    input wire logic [WIDTH-1:0] gpio_sel,
    input wire logic readback,
    // Peripheral side
    input wire logic [WIDTH-1:0] periph_out,
    input wire logic [WIDTH-1:0] periph_oe,
    input wire logic [WIDTH-1:0] periph_nmos,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n,
    output logic [WIDTH-1:0] pullup_en,
    output logic [WIDTH-1:0] cmos_out,
    output logic [WIDTH-1:0] read_val
);
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (gpio_sel[i]) begin
                pin_out[i] = data[i];
                pin_oe_n[i] = dir[i];
                pullup_en[i] = pu[i] & dir[i];
                cmos_out[i] = ~dir[i];
                read_val[i] = (~dir[i] & ~readback) ? data[i] : pin_in[i];
            end else begin
                pin_out[i] = periph_nmos[i] ? 1'b0 : periph_out[i];
                pin_oe_n[i] = ~periph_oe[i] | (periph_nmos[i] & periph_out[i]);
                pullup_en[i] = pu[i] & periph_oe[i] & periph_nmos[i];
                cmos_out[i] = periph_oe[i] & ~periph_nmos[i];
                read_val[i] = pin_in[i];
            end
        end
    end
endmodule // dpgw_pad

// ===== hdl/dpgw_wake.sv
// Falling edge wake-up detector for port A.
// Assumes pins are synchronous to ref_clk.
`timescale 1ns/1ps
module dpgw_wake #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pins and qualifiers
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] arm,
    input wire logic halted,
    // Wake event
    output logic wake_req
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic wake;
    } dpgw_wake_t;

    dpgw_wake_t st, next_st;

    always_comb begin
        next_st.prev = pin_in;
        next_st.wake = halted & |(st.prev & ~pin_in & arm);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wake_req = st.wake;
endmodule // dpgw_wake

// ===== hdl/dpgw_top.sv
// Dual port GPIO block: registers, pad control, drive level and wake-up.
// Assumes the core issues one-cycle read or write strobes on its data bus.
`timescale 1ns/1ps
module dpgw_top
    import dpgw_pkg::*;
#(
    parameter int PA_WIDTH = 8,
    parameter int PB_WIDTH = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Core data-memory bus
    input wire logic [3:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    // Port A pins
    input wire logic [PA_WIDTH-1:0] pa_in,
    output logic [PA_WIDTH-1:0] pa_out,
    output logic [PA_WIDTH-1:0] pa_oe_n,
    output logic [PA_WIDTH-1:0] pa_pullup,
    output logic [2*PA_WIDTH-1:0] pa_drive_level,
    // Port B pins
    input wire logic [PB_WIDTH-1:0] pb_in,
    output logic [PB_WIDTH-1:0] pb_out,
    output logic [PB_WIDTH-1:0] pb_oe_n,
    output logic [PB_WIDTH-1:0] pb_pullup,
    output logic [2*PB_WIDTH-1:0] pb_drive_level,
    // Peripheral drive on port A shared pins
    input wire logic [PA_WIDTH-1:0] periph_out,
    input wire logic [PA_WIDTH-1:0] periph_oe,
    input wire logic [PA_WIDTH-1:0] periph_nmos,
    // Peripheral input routing and selects
    output logic rx_input,
    output logic [7:0] func_select_low,
    output logic [7:0] func_select_high,
    output logic readback_pin_mode,
    // Power management
    input wire logic core_halted,
    output logic wake_req
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pa_data;
        logic [7:0] pa_dir;
        logic [7:0] pa_pu;
        logic [7:0] pa_wu;
        logic [1:0] pb_data;
        logic [1:0] pb_dir;
        logic [1:0] pb_pu;
        logic [5:0] drive;
        logic [7:0] fsel_lo;
        logic [7:0] fsel_hi;
        logic [1:0] in_route;
        logic [7:0] unlock;
        logic [7:0] rdata;
    } dpgw_state_t;

    dpgw_state_t st, next_st;
    logic [PA_WIDTH-1:0] pa_gpio, pa_cmos, pa_rd;
    logic [PB_WIDTH-1:0] pb_cmos, pb_rd;

    // ------------------------------------------------------------------
    // Function select decode
    // ------------------------------------------------------------------
    // True when a pin's 2-bit function field selects general purpose I/O
    function automatic logic is_gpio(input int pin, input logic [1:0] f);
        case (pin)
            0, 2, 3, 4: is_gpio = (f != FSEL_ALT2) && (f != FSEL_ALT3);
            default: is_gpio = (f != FSEL_ALT3);
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pa_gpio[i] = is_gpio(i, st.fsel_lo[2*i +: 2]);
            pa_gpio[i+4] = is_gpio(i + 4, st.fsel_hi[2*i +: 2]);
        end
    end

    // ------------------------------------------------------------------
    // Pads
    // ------------------------------------------------------------------
    dpgw_pad #(.WIDTH(PA_WIDTH)) u_pad_a (
        .data(st.pa_data),
        .dir(st.pa_dir),
        .pu(st.pa_pu),
        .gpio_sel(pa_gpio),
        .readback(readback_pin_mode),
        .periph_out(periph_out),
        .periph_oe(periph_oe),
        .periph_nmos(periph_nmos),
        .pin_in(pa_in),
        .pin_out(pa_out),
        .pin_oe_n(pa_oe_n),
        .pullup_en(pa_pullup),
        .cmos_out(pa_cmos),
        .read_val(pa_rd)
    );

    // Port B has no shared functions
    dpgw_pad #(.WIDTH(PB_WIDTH)) u_pad_b (
        .data(st.pb_data),
        .dir(st.pb_dir),
        .pu(st.pb_pu),
        .gpio_sel({PB_WIDTH{1'b1}}),
        .readback(readback_pin_mode),
        .periph_out({PB_WIDTH{1'b0}}),
        .periph_oe({PB_WIDTH{1'b0}}),
        .periph_nmos({PB_WIDTH{1'b0}}),
        .pin_in(pb_in),
        .pin_out(pb_out),
        .pin_oe_n(pb_oe_n),
        .pullup_en(pb_pullup),
        .cmos_out(pb_cmos),
        .read_val(pb_rd)
    );

    // ------------------------------------------------------------------
    // Drive level per pin
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < PA_WIDTH; i++) begin
            if (!pa_cmos[i]) begin
                pa_drive_level[2*i +: 2] = 2'h0;
            end else if (i < 4) begin
                pa_drive_level[2*i +: 2] = st.drive[DRV_PA_LO_LSB +: 2];
            end else begin
                pa_drive_level[2*i +: 2] = st.drive[DRV_PA_HI_LSB +: 2];
            end
        end
        for (int j = 0; j < PB_WIDTH; j++) begin
            pb_drive_level[2*j +: 2] = pb_cmos[j] ?
                st.drive[DRV_PB_LSB +: 2] : 2'h0;
        end
    end

    // ------------------------------------------------------------------
    // Wake-up
    // ------------------------------------------------------------------
    dpgw_wake #(.WIDTH(PA_WIDTH)) u_wake (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(pa_in),
        .arm(st.pa_wu & pa_gpio & st.pa_dir),
        .halted(core_halted),
        .wake_req(wake_req)
    );

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (mem_wr) begin
            case (mem_addr)
                OFS_PA_DATA: next_st.pa_data = mem_wdata;
                OFS_PA_DIR: next_st.pa_dir = mem_wdata;
                OFS_PA_PU: next_st.pa_pu = mem_wdata;
                OFS_PA_WU: next_st.pa_wu = mem_wdata;
                OFS_PB_DATA: next_st.pb_data = mem_wdata[1:0];
                OFS_PB_DIR: next_st.pb_dir = mem_wdata[1:0];
                OFS_PB_PU: next_st.pb_pu = mem_wdata[1:0];
                OFS_DRIVE: next_st.drive = mem_wdata[5:0];
                OFS_FSEL_LO: next_st.fsel_lo = mem_wdata;
                OFS_FSEL_HI: next_st.fsel_hi = mem_wdata;
                OFS_IN_ROUTE: next_st.in_route = mem_wdata[1:0];
                OFS_UNLOCK: next_st.unlock = mem_wdata;
                default: next_st = st;
            endcase
        end
        if (mem_rd) begin
            case (mem_addr)
                OFS_PA_DATA: next_st.rdata = pa_rd;
                OFS_PA_DIR: next_st.rdata = st.pa_dir;
                OFS_PA_PU: next_st.rdata = st.pa_pu;
                OFS_PA_WU: next_st.rdata = st.pa_wu;
                OFS_PB_DATA: next_st.rdata = {6'h00, pb_rd};
                OFS_PB_DIR: next_st.rdata = {6'h00, st.pb_dir};
                OFS_PB_PU: next_st.rdata = {6'h00, st.pb_pu};
                OFS_DRIVE: next_st.rdata = {2'h0, st.drive};
                OFS_FSEL_LO: next_st.rdata = st.fsel_lo;
                OFS_FSEL_HI: next_st.rdata = st.fsel_hi;
                OFS_IN_ROUTE: next_st.rdata = {6'h00, st.in_route};
                OFS_UNLOCK: next_st.rdata = st.unlock;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.pa_data <= RST_DATA;
            st.pa_dir <= RST_DIR;
            st.pb_data <= RST_DATA[1:0];
            st.pb_dir <= RST_DIR[1:0];
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign mem_rdata = st.rdata;
    assign readback_pin_mode = (st.unlock == UNLOCK_KEY);
    assign rx_input = (st.in_route == RX_SRC_PIN3) ? pa_in[3] : pa_in[0];
    assign func_select_low = st.fsel_lo;
    assign func_select_high = st.fsel_hi;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_read(logic [3:0] a);
        mem_rd && !mem_wr && mem_addr == a;
    endsequence

    sequence s_fall(int i);
        pa_in[i] ##1 !pa_in[i];
    endsequence

    chk_read_live_pin: assert property (@(posedge ref_clk) disable iff (rst)
        s_read(OFS_PA_DATA) ##0 (st.pa_dir == 8'hFF) && (pa_gpio == 8'hFF)
        |=> mem_rdata == $past(pa_in))
        else $error("port A read did not return live pins");

    chk_latch_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !(mem_wr && mem_addr == OFS_PA_DATA) |=> $stable(st.pa_data))
        else $error("port A latch changed without a write");

    chk_pb_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
        s_read(OFS_PB_DIR) |=> mem_rdata[7:2] == 6'h00)
        else $error("port B unimplemented bits not zero");

    chk_pullup_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (pa_gpio[0] && !st.pa_dir[0]) |-> !pa_pullup[0])
        else $error("pull-high on while push-pull output");

    chk_dir_drive: assert property (@(posedge ref_clk) disable iff (rst)
        (mem_wr && mem_addr == OFS_PB_DIR && mem_wdata[0] == 1'b0)
        |=> !pb_oe_n[0] && pb_out[0] == st.pb_data[0])
        else $error("port B pin not driving after direction write");

    chk_readback_latch: assert property (@(posedge ref_clk) disable iff (rst)
        s_read(OFS_PB_DATA) ##0 (st.pb_dir == 2'h0) && !readback_pin_mode
        |=> mem_rdata[1:0] == $past(st.pb_data))
        else $error("output read did not return latch");

    chk_unlock_mode: assert property (@(posedge ref_clk) disable iff (rst)
        (mem_wr && mem_addr == OFS_UNLOCK)
        |=> readback_pin_mode == ($past(mem_wdata) == 8'hCA))
        else $error("readback mode does not follow unlock value");

    chk_wake_edge: assert property (@(posedge ref_clk) disable iff (rst)
        s_fall(0) ##0 (st.pa_wu[0] && st.pa_dir[0] && pa_gpio[0]
        && core_halted && $stable(st)) |=> wake_req)
        else $error("falling edge did not wake core");

    chk_wake_idle: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(core_halted) |-> !wake_req)
        else $error("wake raised while core running");

    chk_drive_gate: assert property (@(posedge ref_clk) disable iff (rst)
        pb_oe_n[1] |-> pb_drive_level[3:2] == 2'h0)
        else $error("drive level on non-output pin");

    chk_rx_route: assert property (@(posedge ref_clk) disable iff (rst)
        (st.in_route == 2'h1) |-> rx_input == pa_in[3])
        else $error("receive input not routed from pin 3");

endmodule // dpgw_top

// ===== verification/dpgw_board.sv
// Board circuitry on the port pins: external drivers, pull-highs, floats.
// Assumes pins are sampled on ref_clk; ext_en models a driver or short.
`timescale 1ns/1ps
module dpgw_board #(
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic ref_clk,
    // Block side
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe_n,
    input wire logic [WIDTH-1:0] pull_en,
    output logic [WIDTH-1:0] pin_in,
    // External drivers, overriding the block where enabled
    input wire logic [WIDTH-1:0] ext_en,
    input wire logic [WIDTH-1:0] ext_val
);
    // ------------------------------------------------------------------
    // Pin level
    // ------------------------------------------------------------------
    // Undriven, unpulled pins wander so a stale value never reads back
    logic [WIDTH-1:0] flt = '0;
    always_ff @(posedge ref_clk) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (pull_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = flt[i];
        end
    end
endmodule // dpgw_board

// ===== verification/tb_top.sv
// Self-checking bench for the dual port GPIO block with wake-up.
// Assumes the board model closes the pins; one clock, synchronous reset.
`timescale 1ns/1ps
module tb_top;
    import dpgw_pkg::*;
    logic ref_clk, rst, mem_wr, mem_rd, rx_input, readback_pin_mode;
    logic core_halted, wake_req;
    logic [3:0] mem_addr, pb_drive_level;
    logic [7:0] mem_wdata, mem_rdata, pa_in, pa_out, pa_oe_n, pa_pullup;
    logic [7:0] periph_out, periph_oe, periph_nmos, xa_en, xa_val;
    logic [7:0] func_select_low, func_select_high;
    logic [15:0] pa_drive_level;
    logic [1:0] pb_in, pb_out, pb_oe_n, pb_pullup, xb_en, xb_val;
    int failures, cmp_count, cyc;

    dpgw_top dut (.ref_clk(ref_clk), .rst(rst), .mem_addr(mem_addr),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .pa_in(pa_in), .pa_out(pa_out),
        .pa_oe_n(pa_oe_n), .pa_pullup(pa_pullup),
        .pa_drive_level(pa_drive_level), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe_n(pb_oe_n), .pb_pullup(pb_pullup),
        .pb_drive_level(pb_drive_level), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_nmos(periph_nmos),
        .rx_input(rx_input), .func_select_low(func_select_low),
        .func_select_high(func_select_high),
        .readback_pin_mode(readback_pin_mode), .core_halted(core_halted),
        .wake_req(wake_req));
    dpgw_board #(.WIDTH(8)) board_a (.ref_clk(ref_clk), .pin_out(pa_out),
        .pin_oe_n(pa_oe_n), .pull_en(pa_pullup), .pin_in(pa_in),
        .ext_en(xa_en), .ext_val(xa_val));
    dpgw_board #(.WIDTH(2)) board_b (.ref_clk(ref_clk), .pin_out(pb_out),
        .pin_oe_n(pb_oe_n), .pull_en(pb_pullup), .pin_in(pb_in),
        .ext_en(xb_en), .ext_val(xb_val));

    // ------------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic test_done;
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        mem_addr <= a;
        mem_wdata <= d;
        mem_wr <= 1'b1;
        @(posedge ref_clk);
        mem_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp,
                       input string nm);
        @(posedge ref_clk);
        mem_addr <= a;
        mem_rd <= 1'b1;
        @(posedge ref_clk);
        mem_rd <= 1'b0;
        @(posedge ref_clk);
        #1 chk(nm, {8'h00, exp}, {8'h00, mem_rdata});
    endtask
    task automatic setx(input logic [7:0] v);
        @(posedge ref_clk);
        xa_val <= v;
        #1;
    endtask
    task automatic wake_try(input logic [7:0] fall, input int exp);
        int n = 0;
        setx(8'hFF);
        repeat (2) @(posedge ref_clk);
        setx(~fall);
        repeat (5) begin
            @(posedge ref_clk);
            #1 n += int'(wake_req === 1'b1);
        end
        chk("wake_req pulses", 16'(exp), 16'(n));
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    logic [7:0] rst_exp [13] = '{8'h5A, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h03,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0] wa [9] = '{OFS_PA_PU, OFS_PA_WU, OFS_FSEL_LO, OFS_FSEL_HI,
        OFS_PB_DIR, OFS_PB_PU, OFS_DRIVE, OFS_IN_ROUTE, 4'hC};
    logic [7:0] we [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h03, 8'h3F,
        8'h03, 8'h00};
    initial begin
        logic [1:0] d;
        rst = 1'b1;
        {mem_wr, mem_rd, core_halted} = 3'h0;
        mem_addr = 4'h0;
        mem_wdata = 8'h00;
        {periph_out, periph_oe, periph_nmos} = 24'h000000;
        xa_en = 8'hFF;
        xa_val = 8'h5A;
        xb_en = 2'h3;
        xb_val = 2'h2;
        failures = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // Offsets are consecutive from zero, C is unmapped
        for (int i = 0; i < 13; i++) rdc(4'(i), rst_exp[i], "reset");
        chk("pa_oe_n", 16'h00FF, {8'h00, pa_oe_n});
        for (int i = 0; i < 9; i++) begin
            wr(wa[i], 8'hFF);
            rdc(wa[i], we[i], "masked reg");
        end
        chk("func_select_high", 16'h00FF, {8'h00, func_select_high});
        chk("pb_pullup", 16'h0003, {14'h0000, pb_pullup});
        for (int i = 0; i < 9; i++) wr(wa[i], 8'h00);
        chk("func_select_low", 16'h0000, {8'h00, func_select_low});
        chk("pb_oe_n", 16'h0000, {14'h0000, pb_oe_n});
        // Latch versus pin readback
        wr(OFS_PA_DATA, 8'h3C);
        wr(OFS_PA_DIR, 8'hF0);
        chk("pa_oe_n", 16'h00F0, {8'h00, pa_oe_n});
        setx(8'hA5);
        rdc(OFS_PA_DATA, 8'hAC, "latch read");
        wr(OFS_UNLOCK, 8'hCA);
        chk("readback_pin_mode", 16'h1, {15'h0, readback_pin_mode});
        rdc(OFS_PA_DATA, 8'hA5, "pin read");
        wr(OFS_UNLOCK, 8'hCB);
        chk("readback_pin_mode", 16'h0, {15'h0, readback_pin_mode});
        rdc(OFS_PA_DATA, 8'hAC, "latch read");
        // Pull-highs
        wr(OFS_PA_PU, 8'hFF);
        chk("pa_pullup", 16'h00F0, {8'h00, pa_pullup});
        @(posedge ref_clk) xa_en <= 8'h00;
        rdc(OFS_PA_DATA, 8'hFC, "pulled read");
        chk("pa_out", 16'h000C, {12'h000, pa_out[3:0]});
        wr(OFS_PA_DIR, 8'hFF);
        wr(OFS_FSEL_LO, 8'h02);
        @(posedge ref_clk) {periph_oe, periph_out} <= 16'h0101;
        #1 chk("pa_pullup", 16'h00FE, {8'h00, pa_pullup});
        chk("pa_out", 16'h0001, {15'h0, pa_out[0]});
        @(posedge ref_clk) periph_nmos <= 8'h01;
        #1 chk("pa_pullup", 16'h00FF, {8'h00, pa_pullup});
        chk("pa_oe_n", 16'h00FF, {8'h00, pa_oe_n});
        @(posedge ref_clk) periph_oe <= 8'h00;
        wr(OFS_FSEL_LO, 8'h00);
        wr(OFS_PA_PU, 8'h00);
        @(posedge ref_clk) xa_en <= 8'hFF;
        // Source drive levels
        wr(OFS_PA_DIR, 8'h00);
        wr(OFS_PB_DIR, 8'h00);
        for (int c = 0; c < 4; c++) begin
            d = 2'(c);
            wr(OFS_DRIVE, {2'b00, d, ~d, d});
            chk("pa_drive_level", {{4{~d}}, {4{d}}}, pa_drive_level);
            chk("pb_drive_level", {12'h000, d, d}, {12'h000, pb_drive_level});
        end
        wr(OFS_PA_DIR, 8'hFF);
        chk("pa_drive_level", 16'h0000, pa_drive_level);
        wr(OFS_PB_DATA, 8'hFF);
        chk("pb_out", 16'h0003, {14'h0000, pb_out});
        rdc(OFS_PB_DATA, 8'h03, "pb latch");
        // Receive input routing
        for (int c = 0; c < 4; c++) begin
            wr(OFS_IN_ROUTE, 8'(c));
            setx(8'h08);
            chk("rx_input", 16'(c == 1), {15'h0, rx_input});
            setx(8'h01);
            chk("rx_input", 16'(c != 1), {15'h0, rx_input});
        end
        // Wake-up
        @(posedge ref_clk) core_halted <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_PA_WU, 8'(1 << i));
            wake_try(8'(1 << i), 1);
            wake_try(~8'(1 << i), 0);
        end
        wr(OFS_PA_WU, 8'hFF);
        @(posedge ref_clk) core_halted <= 1'b0;
        wake_try(8'hFF, 0);
        @(posedge ref_clk) core_halted <= 1'b1;
        wr(OFS_PA_DIR, 8'hFE);
        wake_try(8'h01, 0);
        wake_try(8'h02, 1);
        wr(OFS_PA_DIR, 8'hFF);
        wr(OFS_FSEL_LO, 8'h02);
        wake_try(8'h01, 0);
        test_done();
    end
endmodule // tb_top
